// ### core/seq_slot_regs.vh
// register map, field positions and reset values of the sequencer slot bank
`ifndef SEQ_SLOT_REGS_VH
`define SEQ_SLOT_REGS_VH

`define SSR_BUS_ADDR            7'h60
`define SSR_OFS_EXT_REG1_SEQ    8'h24
`define SSR_OFS_EXT_REG2_SEQ    8'h25
`define SSR_OFS_PWR_MODE1       8'h26
`define SSR_RST_EXT_REG1_SEQ    8'h85
`define SSR_RST_EXT_REG2_SEQ    8'h97
`define SSR_RST_PWR_MODE1       8'h55

`define SSR_SEQ_ASSIGN_BIT      7
`define SSR_SEQ_MASTER_HI       6
`define SSR_SEQ_MASTER_LO       4
`define SSR_SEQ_UP_HI           3
`define SSR_SEQ_UP_LO           2
`define SSR_SEQ_DOWN_HI         1
`define SSR_SEQ_DOWN_LO         0
`define SSR_MASTER_COUNT        6

`define SSR_PM_SLEEP_RST_BIT    7
`define SSR_PM_SLEEP_WP_BIT     6
`define SSR_PM_BUCK3_HI         5
`define SSR_PM_BUCK3_LO         4
`define SSR_PM_BUCK2_HI         3
`define SSR_PM_BUCK2_LO         2
`define SSR_PM_BUCK1_HI         1
`define SSR_PM_BUCK1_LO         0

`endif

// ### core/ext_out_route.v
// decodes one external-regulator sequencer byte into master and slot outputs
`timescale 1ns/1ps
`include "seq_slot_regs.vh"

module ext_out_route
(
  input  wire       i_clk_sys,        // system clock
  input  wire       i_reset,          // async reset, active high
  input  wire [7:0] i_cfg,            // sequencer config byte
  output reg        o_assigned,       // output owned by a valid master
  output reg  [5:0] o_master_onehot,  // one-hot master select
  output reg  [1:0] o_up_slot,        // power-up slot
  output reg  [1:0] o_down_slot       // power-down slot
);

  wire [2:0] master_code_w;
  wire [5:0] master_onehot_nxt;

  assign master_code_w = i_cfg[`SSR_SEQ_MASTER_HI:`SSR_SEQ_MASTER_LO];
  // codes 6 and 7 shift out of the six bits, so a reserved code owns nothing
  assign master_onehot_nxt = i_cfg[`SSR_SEQ_ASSIGN_BIT] ?
                             (6'h01 << master_code_w) : 6'h00; // RL1 RL2 RL9

  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_assigned      <= 1'b0;
      o_master_onehot <= 6'h00;
      o_up_slot       <= 2'h0;
      o_down_slot     <= 2'h0;
    end
    else
    begin
      o_assigned      <= |master_onehot_nxt; // RL1
      o_master_onehot <= master_onehot_nxt;
      o_up_slot       <= i_cfg[`SSR_SEQ_UP_HI:`SSR_SEQ_UP_LO]; // RL3
      o_down_slot     <= i_cfg[`SSR_SEQ_DOWN_HI:`SSR_SEQ_DOWN_LO]; // RL4
    end
  end

endmodule // ext_out_route

// ### core/seq_slot_power_regs.v
// two-wire slave with the sequencer slot and power-mode register bank
// Notes on behaviour
// RL1 - assign bit clear: output has no master
// RL2 - master codes 0-5 valid, 6-7 reserved
// RL3 - bits 3:2 pick power-up slot
// RL4 - bits 1:0 pick power-down slot
// RL5 - sleep entry pulls system reset low
// RL6 - sleep entry pulls write protect low
// RL7 - sleep controls act in slave mode only
// RL8 - three buck power-mode fields forwarded
// RL9 - reserved master code leaves output unassigned
// RL10 - registers read/write, reset to defaults
`timescale 1ns/1ps
`include "seq_slot_regs.vh"

module seq_slot_power_regs
(
  input  wire        i_clk_sys,                  // 200 MHz system clock
  input  wire        i_reset,                    // async reset, active high
  input  wire        i_scl,                      // serial clock pin
  input  wire        i_sda,                      // serial data pin level
  output reg         o_sda_out,                  // serial data drive value
  output reg         o_sda_oe,                   // serial data drive enable
  input  wire        i_device_sleep,             // sleep entry sequence active
  input  wire        i_slave_mode,               // device runs in slave mode
  input  wire        i_sys_reset_n,              // reset level from on/off logic
  input  wire        i_write_protect_n,          // protect level from on/off logic
  output reg         o_sys_reset_n,              // system reset output, active low
  output reg         o_write_protect_n,          // write protect output, active low
  output wire [1:0]  o_ext_out_assigned,         // per output: owned by a master
  output wire [11:0] o_ext_out_master_onehot,    // per output: 6-bit one-hot master
  output wire [3:0]  o_ext_out_up_slot,          // per output: power-up slot
  output wire [3:0]  o_ext_out_down_slot,        // per output: power-down slot
  output reg  [1:0]  o_buck_one_power_mode,      // buck 1 power-mode code
  output reg  [1:0]  o_buck_two_power_mode,      // buck 2 power-mode code
  output reg  [1:0]  o_buck_three_power_mode     // buck 3 power-mode code
);

  parameter [6:0] BUS_ADDR = `SSR_BUS_ADDR;

  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_ADDR  = 7'h02;
  localparam [6:0] ST_AACK  = 7'h04;
  localparam [6:0] ST_WDATA = 7'h08;
  localparam [6:0] ST_WACK  = 7'h10;
  localparam [6:0] ST_RDATA = 7'h20;
  localparam [6:0] ST_RACK  = 7'h40;

  reg  [7:0]  ext1_cfg_r;
  reg  [7:0]  ext2_cfg_r;
  reg  [7:0]  pwr_mode_r;
  reg  [1:0]  scl_sync_r;
  reg  [1:0]  sda_sync_r;
  reg         scl_d_r;
  reg         sda_d_r;
  reg  [6:0]  state_r;
  reg  [3:0]  bit_cnt_r;
  reg  [7:0]  shift_r;
  reg  [7:0]  rd_shift_r;
  reg  [7:0]  ptr_r;
  reg         ptr_phase_r;
  reg         read_r;
  reg         nack_r;
  reg  [7:0]  rd_data_w;
  wire        scl_w;
  wire        sda_w;
  wire        scl_rise_w;
  wire        scl_fall_w;
  wire        start_w;
  wire        stop_w;
  wire        sleep_act_w;
  wire [15:0] ext_cfg_bus_w;

  assign scl_w      = scl_sync_r[1];
  assign sda_w      = sda_sync_r[1];
  assign scl_rise_w = scl_w & ~scl_d_r;
  assign scl_fall_w = ~scl_w & scl_d_r;
  assign start_w    = scl_w & scl_d_r & sda_d_r & ~sda_w;
  assign stop_w     = scl_w & scl_d_r & ~sda_d_r & sda_w;

  // unmapped offsets read as zero so a host scan sees a clean bus
  always @*
  begin
    case (ptr_r)
      `SSR_OFS_EXT_REG1_SEQ: rd_data_w = ext1_cfg_r; // RL10
      `SSR_OFS_EXT_REG2_SEQ: rd_data_w = ext2_cfg_r; // RL10
      `SSR_OFS_PWR_MODE1:    rd_data_w = pwr_mode_r; // RL10
      default:               rd_data_w = 8'h00;
    endcase
  end

  // pins come from another domain; edges are judged on the second stage only
  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], i_scl};
      sda_sync_r <= {sda_sync_r[0], i_sda};
      scl_d_r    <= scl_w;
      sda_d_r    <= sda_w;
    end
  end

  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_r     <= ST_IDLE;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      rd_shift_r  <= 8'h00;
      ptr_r       <= 8'h00;
      ptr_phase_r <= 1'b0;
      read_r      <= 1'b0;
      nack_r      <= 1'b0;
      o_sda_out   <= 1'b0;
      o_sda_oe    <= 1'b0;
      ext1_cfg_r  <= `SSR_RST_EXT_REG1_SEQ; // RL10
      ext2_cfg_r  <= `SSR_RST_EXT_REG2_SEQ; // RL10
      pwr_mode_r  <= `SSR_RST_PWR_MODE1; // RL10
    end
    else if (start_w)
    begin
      state_r     <= ST_ADDR;
      bit_cnt_r   <= 4'h0;
      ptr_phase_r <= 1'b1;
      o_sda_oe    <= 1'b0;
    end
    else if (stop_w)
    begin
      state_r  <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          o_sda_oe <= 1'b0;
        end
        ST_ADDR, ST_WDATA:
        begin
          if (scl_rise_w)
          begin
            shift_r   <= {shift_r[6:0], sda_w};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (scl_fall_w && bit_cnt_r == 4'h8)
          begin
            bit_cnt_r <= 4'h0;
            if (state_r == ST_ADDR)
            begin
              if (shift_r[7:1] == BUS_ADDR)
              begin
                read_r   <= shift_r[0];
                o_sda_oe <= 1'b1;
                state_r  <= ST_AACK;
              end
              else
                state_r <= ST_IDLE;
            end
            else
            begin
              // first byte after the address is the register pointer
              if (ptr_phase_r)
              begin
                ptr_r       <= shift_r;
                ptr_phase_r <= 1'b0;
              end
              else
              begin
                if (ptr_r == `SSR_OFS_EXT_REG1_SEQ)
                  ext1_cfg_r <= shift_r; // RL10
                if (ptr_r == `SSR_OFS_EXT_REG2_SEQ)
                  ext2_cfg_r <= shift_r; // RL10
                if (ptr_r == `SSR_OFS_PWR_MODE1)
                  pwr_mode_r <= shift_r; // RL10
                ptr_r <= ptr_r + 8'h01;
              end
              o_sda_oe <= 1'b1;
              state_r  <= ST_WACK;
            end
          end
        end
        ST_AACK:
        begin
          if (scl_fall_w)
          begin
            bit_cnt_r <= 4'h0;
            if (read_r)
            begin
              o_sda_oe   <= ~rd_data_w[7];
              rd_shift_r <= {rd_data_w[6:0], 1'b0};
              state_r    <= ST_RDATA;
            end
            else
            begin
              o_sda_oe <= 1'b0;
              state_r  <= ST_WDATA;
            end
          end
        end
        ST_WACK:
        begin
          if (scl_fall_w)
          begin
            o_sda_oe <= 1'b0;
            state_r  <= ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_rise_w)
            bit_cnt_r <= bit_cnt_r + 4'h1;
          else if (scl_fall_w)
          begin
            if (bit_cnt_r == 4'h8)
            begin
              o_sda_oe <= 1'b0;
              ptr_r    <= ptr_r + 8'h01;
              state_r  <= ST_RACK;
            end
            else
            begin
              o_sda_oe   <= ~rd_shift_r[7];
              rd_shift_r <= {rd_shift_r[6:0], 1'b0};
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise_w)
            nack_r <= sda_w;
          else if (scl_fall_w)
          begin
            bit_cnt_r <= 4'h0;
            if (nack_r)
              state_r <= ST_IDLE;
            else
            begin
              o_sda_oe   <= ~rd_data_w[7];
              rd_shift_r <= {rd_data_w[6:0], 1'b0};
              state_r    <= ST_RDATA;
            end
          end
        end
        default:
        begin
          state_r  <= ST_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // sleep pulls only low; otherwise the on/off logic keeps control of the pins
  assign sleep_act_w = i_device_sleep & i_slave_mode; // RL7

  always @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_sys_reset_n           <= 1'b0;
      o_write_protect_n       <= 1'b0;
      o_buck_one_power_mode   <= 2'h0;
      o_buck_two_power_mode   <= 2'h0;
      o_buck_three_power_mode <= 2'h0;
    end
    else
    begin
      o_sys_reset_n     <= (sleep_act_w && pwr_mode_r[`SSR_PM_SLEEP_RST_BIT]) ?
                           1'b0 : i_sys_reset_n; // RL5
      o_write_protect_n <= (sleep_act_w && pwr_mode_r[`SSR_PM_SLEEP_WP_BIT]) ?
                           1'b0 : i_write_protect_n; // RL6
      o_buck_one_power_mode   <= pwr_mode_r[`SSR_PM_BUCK1_HI:`SSR_PM_BUCK1_LO]; // RL8
      o_buck_two_power_mode   <= pwr_mode_r[`SSR_PM_BUCK2_HI:`SSR_PM_BUCK2_LO]; // RL8
      o_buck_three_power_mode <= pwr_mode_r[`SSR_PM_BUCK3_HI:`SSR_PM_BUCK3_LO]; // RL8
    end
  end

  assign ext_cfg_bus_w = {ext2_cfg_r, ext1_cfg_r};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_ext_out
      ext_out_route u_route
      (
        .i_clk_sys       (i_clk_sys),
        .i_reset         (i_reset),
        .i_cfg           (ext_cfg_bus_w[g*8 +: 8]),
        .o_assigned      (o_ext_out_assigned[g]),
        .o_master_onehot (o_ext_out_master_onehot[g*6 +: 6]),
        .o_up_slot       (o_ext_out_up_slot[g*2 +: 2]),
        .o_down_slot     (o_ext_out_down_slot[g*2 +: 2])
      );
    end
  endgenerate

endmodule // seq_slot_power_regs

// ### testbench/seq_slot_power_regs_monitor.sv
// assertion checker for the sequencer slot and power-mode bank
`timescale 1ns/1ps
module seq_slot_power_regs_monitor
(
  input wire        i_clk_sys,               // clock
  input wire        i_reset,                 // reset
  input wire        i_device_sleep,          // sleep entry
  input wire        i_slave_mode,            // slave mode
  input wire        i_sys_reset_n,           // reset level in
  input wire        i_write_protect_n,       // protect level in
  input wire        o_sys_reset_n,           // reset out
  input wire        o_write_protect_n,       // protect out
  input wire [1:0]  o_ext_out_assigned,      // owned flags
  input wire [11:0] o_ext_out_master_onehot  // one-hot masters
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  free_one_a:
    assert property (!o_ext_out_assigned[0] |-> o_ext_out_master_onehot[5:0] == 6'h00)
    else $error("output one has a master while unassigned");
  free_two_a:
    assert property (!o_ext_out_assigned[1] |-> o_ext_out_master_onehot[11:6] == 6'h00)
    else $error("output two has a master while unassigned");
  onehot_one_a:
    assert property (o_ext_out_assigned[0] |-> $onehot(o_ext_out_master_onehot[5:0]))
    else $error("output one master not one-hot");
  onehot_two_a:
    assert property (o_ext_out_assigned[1] |-> $onehot(o_ext_out_master_onehot[11:6]))
    else $error("output two master not one-hot");
  awake_reset_a:
    assert property (!i_device_sleep |=> o_sys_reset_n == $past(i_sys_reset_n))
    else $error("reset out altered outside sleep");
  awake_protect_a:
    assert property (!i_device_sleep |=> o_write_protect_n == $past(i_write_protect_n))
    else $error("protect out altered outside sleep");
  master_reset_a:
    assert property (!i_slave_mode |=> o_sys_reset_n == $past(i_sys_reset_n))
    else $error("reset out altered outside slave mode");
  master_protect_a:
    assert property (!i_slave_mode |=> o_write_protect_n == $past(i_write_protect_n))
    else $error("protect out altered outside slave mode");
endmodule // seq_slot_power_regs_monitor

// ### testbench/host_model.sv
// two-wire host model: drives the serial clock, pulls the data line low
`timescale 1ns/1ps
module host_model
(
  input  wire i_clk_sys,  // system clock
  input  wire i_sda,      // resolved data line
  output reg  o_scl,      // serial clock
  output reg  o_sda_low   // pulls data low
);
  reg r;
  initial
  begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  // eight cycles a phase, twice the slave's minimum
  task hold;
    repeat (8) @(negedge i_clk_sys);
  endtask
  task start;
    begin
      o_sda_low = 1'b0;
      hold;
      o_scl = 1'b1;
      hold;
      o_sda_low = 1'b1;
      hold;
      o_scl = 1'b0;
      hold;
    end
  endtask
  task stop;
    begin
      o_sda_low = 1'b1;
      hold;
      o_scl = 1'b1;
      hold;
      o_sda_low = 1'b0;
      hold;
    end
  endtask
  // data only moves while the clock is low
  task bit_io(input logic b);
    begin
      o_sda_low = ~b;
      hold;
      o_scl = 1'b1;
      hold;
      r = i_sda;
      o_scl = 1'b0;
      hold;
    end
  endtask
  task xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        bit_io(d[i]);
        q[i] = r;
      end
      bit_io(last);
      ack = r;
    end
  endtask
endmodule // host_model

// ### testbench/seq_slot_power_regs_test.sv
// self-checking bench for the sequencer slot and power-mode bank
`timescale 1ns/1ps
module seq_slot_power_regs_test;
  reg          i_clk_sys, i_reset, i_device_sleep, i_slave_mode, i_sys_reset_n, i_write_protect_n;
  wire         scl, sda_low, sda_oe, sda_out, sda, o_sys_reset_n, o_write_protect_n;
  wire [1:0]   assigned, buck1, buck2, buck3;
  wire [11:0]  onehot;
  wire [3:0]   up_slot, down_slot;
  integer      n_fail = 0, compares = 0, k;
  logic [15:0] sq[$], eq[$];
  logic [7:0]  c1, c2, pm, q, v;
  logic [31:0] rnd;
  logic        a;
  // released line floats to the pull-up; a driven line shows the drive value
  assign sda = ~sda_low & (sda_oe ? sda_out : 1'b1);
  seq_slot_power_regs dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_device_sleep(i_device_sleep),
    .i_slave_mode(i_slave_mode), .i_sys_reset_n(i_sys_reset_n),
    .i_write_protect_n(i_write_protect_n), .o_sys_reset_n(o_sys_reset_n),
    .o_write_protect_n(o_write_protect_n), .o_ext_out_assigned(assigned),
    .o_ext_out_master_onehot(onehot), .o_ext_out_up_slot(up_slot),
    .o_ext_out_down_slot(down_slot), .o_buck_one_power_mode(buck1),
    .o_buck_two_power_mode(buck2), .o_buck_three_power_mode(buck3));
  host_model h (.i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  initial
  begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task check(input logic [15:0] seen, exp);
    begin
      compares = compares + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task note(input logic [15:0] seen, exp);
    begin
      eq.push_back(exp);
      sq.push_back(seen);
    end
  endtask
  initial
    forever
    begin
      wait (sq.size() > 0);
      check(sq.pop_front(), eq.pop_front());
    end
  task close_out;
    begin
      #1;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task wr(input logic [7:0] p, d);
    begin
      h.start;
      h.xfer(8'hc0, 1'b1, q, a);
      h.xfer(p, 1'b1, q, a);
      h.xfer(d, 1'b1, q, a);
      note(a, 1'b0);
      h.stop;
    end
  endtask
  task rd(input logic [7:0] p, exp);
    begin
      h.start;
      h.xfer(8'hc0, 1'b1, q, a);
      h.xfer(p, 1'b1, q, a);
      h.start;
      h.xfer(8'hc1, 1'b1, q, a);
      h.xfer(8'hff, 1'b1, v, a);
      h.stop;
      note(v, exp);
    end
  endtask
  // assign, one-hot master, up slot, down slot
  function logic [10:0] dec(input logic [7:0] r);
    begin
      dec = {r[7] && r[6:4] < 3'h6, 6'h00, r[3:0]};
      if (dec[10])
        dec[9:4] = 6'h01 << r[6:4];
    end
  endfunction
  task outs;
    begin
      note({assigned[0], onehot[5:0], up_slot[1:0], down_slot[1:0]}, dec(c1));
      note({assigned[1], onehot[11:6], up_slot[3:2], down_slot[3:2]}, dec(c2));
      note({buck3, buck2, buck1}, pm[5:0]);
    end
  endtask
  task reset_check;
    begin
      c1 = 8'h85;
      c2 = 8'h97;
      pm = 8'h55;
      outs;
      rd(8'h24, c1);
      rd(8'h25, c2);
      rd(8'h26, pm);
    end
  endtask
  initial
  begin
    {i_reset, i_device_sleep, i_slave_mode, i_sys_reset_n, i_write_protect_n} = 5'h13;
    void'($urandom(54));
    repeat (10) @(negedge i_clk_sys);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    reset_check;
    for (k = 0; k < 10; k = k + 1)
    begin
      rnd = $urandom;
      c1 = rnd[7:0];
      c1[7:4] = (k < 8) ? {1'b1, k[2:0]} : {1'b0, c1[6:4]};
      c2 = rnd[15:8];
      pm = rnd[23:16];
      // awake: outputs must follow the on/off levels whatever the sleep bits hold
      {i_sys_reset_n, i_write_protect_n} = rnd[25:24];
      wr(8'h24, c1);
      wr(8'h25, c2);
      wr(8'h26, pm);
      outs;
      note({o_sys_reset_n, o_write_protect_n}, rnd[25:24]);
      rd(8'h24, c1);
    end
    {i_sys_reset_n, i_write_protect_n} = 2'b11;
    wr(8'h26, 8'hc0);
    {i_device_sleep, i_slave_mode} = 2'b11;
    repeat (2) @(negedge i_clk_sys);
    note({o_sys_reset_n, o_write_protect_n}, 2'b00);
    i_slave_mode = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    note({o_sys_reset_n, o_write_protect_n}, 2'b11);
    i_slave_mode = 1'b1;
    wr(8'h26, 8'h40);
    note({o_sys_reset_n, o_write_protect_n}, 2'b10);
    i_device_sleep = 1'b0;
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00);
    h.start;
    h.xfer(8'h62, 1'b1, q, a);
    note(a, 1'b1);
    h.stop;
    i_reset = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    reset_check;
    close_out;
  end
  initial
  begin
    // about twice the roughly 40,000 cycles the scenarios need
    #400000;
    n_fail = n_fail + 1;
    close_out;
  end
endmodule // seq_slot_power_regs_test
bind seq_slot_power_regs seq_slot_power_regs_monitor mon (.i_clk_sys(i_clk_sys),
  .i_reset(i_reset), .i_device_sleep(i_device_sleep), .i_slave_mode(i_slave_mode),
  .i_sys_reset_n(i_sys_reset_n), .i_write_protect_n(i_write_protect_n),
  .o_sys_reset_n(o_sys_reset_n), .o_write_protect_n(o_write_protect_n),
  .o_ext_out_assigned(o_ext_out_assigned), .o_ext_out_master_onehot(o_ext_out_master_onehot));
